// >>> logic/acsp_defines.svh
// Constants of the converter serial port: offsets, field positions, timing
`ifndef ACSP_DEFINES_SVH
`define ACSP_DEFINES_SVH

// ==========================================================================
// Widths
`define ACSP_RESULT_BITS    12
`define ACSP_CFG_BITS       6
`define ACSP_ADR_BITS       8
`define ACSP_CONV_CNT_BITS  8

// ==========================================================================
// Register offsets (byte addresses)
`define ACSP_REG_CTRL       8'h00
`define ACSP_REG_STATUS     8'h04
`define ACSP_REG_CONFIG     8'h08
`define ACSP_REG_RESULT     8'h0C

// ==========================================================================
// Field positions, reset values and config bit counts
`define ACSP_CTRL_ENABLE    0
`define ACSP_CTRL_RESET     1'h1
`define ACSP_ST_BUSY        0
`define ACSP_ST_FRAME       1
`define ACSP_ST_ACQUIRE     2
`define ACSP_ST_SLEEP       3
`define ACSP_ST_FIFO_EMPTY  4
`define ACSP_ST_FIFO_FULL   5
`define ACSP_ST_CFG_CNT     8
`define ACSP_CFG_LAST       3'h5
`define ACSP_CFG_CNT_DONE   3'h6
// Idle pin levels in synchroniser order: trigger high, shift clock and config low
`define ACSP_SYNC_IDLE      3'h4

// ==========================================================================
// Timing
`define ACSP_CLK_PERIOD_NS  10
`define ACSP_T_CONV_NS      1600
`define ACSP_T_EN_NS        15

`endif

// >>> logic/acsp_pkg.sv
// Types shared by the converter serial port modules
package acsp_pkg;

  // ========================================================================
  // Conversion engine states
  typedef enum logic [0:0] {
    ACSP_CONV_IDLE,
    ACSP_CONV_RUN
  } acsp_conv_e;

  // ========================================================================
  // Configuration word, first shifted bit at the top
  typedef struct packed {
    logic single_diff;
    logic odd_sign;
    logic channel_addr_hi;
    logic channel_addr_lo;
    logic polarity_select;
    logic sleep_select;
  } acsp_cfg_s;

endpackage : acsp_pkg

// >>> logic/acsp_stream_if.sv
// Valid/ready stream carrying conversion results between modules
`timescale 1ns/1ps

interface acsp_stream_if #(
  parameter int WIDTH = 12
);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  // Source drives data and valid, sink answers with ready
  modport tx (output data, output valid, input ready);
  modport rx (input data, input valid, output ready);
endinterface : acsp_stream_if

// >>> logic/acsp_fifo.sv
// Synchronous FIFO between the conversion engine and the result latch
`timescale 1ns/1ps

module acsp_fifo
  import acsp_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  acsp_stream_if.rx  in_if,
  acsp_stream_if.tx  out_if,
  output logic       empty_o,
  output logic       full_o
);

  localparam int AW = $clog2(DEPTH);

  // ========================================================================
  // Parameter check: pointer wrap needs a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
    $error("acsp_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      wr_ptr_next;
  logic [AW:0]      rd_ptr_reg;
  logic [AW:0]      rd_ptr_next;
  logic             push;
  logic             pop;

  // ========================================================================
  // Flags: extra pointer bit tells full from empty
  assign empty_o      = (wr_ptr_reg == rd_ptr_reg);
  assign full_o       = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign in_if.ready  = ~full_o;
  assign out_if.valid = ~empty_o;
  assign out_if.data  = mem[rd_ptr_reg[AW-1:0]];
  assign push         = in_if.valid & ~full_o;
  assign pop          = out_if.ready & ~empty_o;

  // Pointer next values
  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    if (push) begin
      wr_ptr_next = wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = rd_ptr_reg + 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Storage, no reset needed: never read while empty
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_if.data;
    end
  end

endmodule : acsp_fifo

// >>> logic/acsp_top.sv
// Conversion control and serial port of the eight-channel 12-bit converter
`timescale 1ns/1ps
`include "acsp_defines.svh"


module acsp_top
  import acsp_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [`ACSP_ADR_BITS-1:0]    wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic                         conversion_trigger_i,
  input  wire logic                         sck_i,
  input  wire logic                         serial_config_in_i,
  output logic                              serial_result_out_o,
  output logic                              serial_result_out_oe_o,
  input  wire logic [`ACSP_RESULT_BITS-1:0] analog_code_i,
  output logic                              sample_acquire_o,
  output logic                              converting_o,
  output logic      [3:0]                   mux_select_o,
  output logic                              polarity_select_o,
  output logic                              sleep_select_o
);

  localparam int RW = `ACSP_RESULT_BITS;
  localparam int CW = `ACSP_CFG_BITS;
  // Least conversion time rounds up to whole cycles
  localparam int CONV_CYCLES = (`ACSP_T_CONV_NS + `ACSP_CLK_PERIOD_NS - 1) / `ACSP_CLK_PERIOD_NS;
  localparam logic [`ACSP_CONV_CNT_BITS-1:0] CONV_LAST = `ACSP_CONV_CNT_BITS'(CONV_CYCLES - 1);

  // ========================================================================
  // Parameter check
  if (CONV_CYCLES < 1 || CONV_CYCLES > (1 << `ACSP_CONV_CNT_BITS)) begin : g_bad_conv
    $error("acsp_top: conversion time does not fit its counter");
  end

  // ========================================================================
  // Pin synchronisers: trigger, shift clock, config data
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] prev_reg;
  logic       trig_s;
  logic       sck_s;
  logic       cfg_bit_s;
  logic       trig_rise;
  logic       trig_fall;
  logic       sck_rise;
  logic       sck_fall;

  // Edge detectors look only at the second stage and its delayed copy
  // Reset to the idle pin levels, so no false edge follows reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= `ACSP_SYNC_IDLE;
      sync2_reg <= `ACSP_SYNC_IDLE;
      prev_reg  <= `ACSP_SYNC_IDLE;
    end else begin
      sync1_reg <= {conversion_trigger_i, sck_i, serial_config_in_i};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign trig_s    = sync2_reg[2];
  assign sck_s     = sync2_reg[1];
  assign cfg_bit_s = sync2_reg[0];
  assign trig_rise = trig_s & ~prev_reg[2];
  assign trig_fall = ~trig_s & prev_reg[2];
  assign sck_rise  = sck_s & ~prev_reg[1];
  assign sck_fall  = ~sck_s & prev_reg[1];

  // ========================================================================
  // Result FIFO between conversion engine and result latch
  acsp_stream_if #(.WIDTH(RW)) push_if ();
  acsp_stream_if #(.WIDTH(RW)) pop_if ();
  logic fifo_empty;
  logic fifo_full;

  acsp_fifo #(
    .WIDTH (RW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .in_if   (push_if),
    .out_if  (pop_if),
    .empty_o (fifo_empty),
    .full_o  (fifo_full)
  );

  // ========================================================================
  // Register state
  logic enable_reg;
  logic enable_next;
  logic conv_start;

  // ========================================================================
  // Serial port group
  logic            frame_reg;
  logic            frame_next;
  logic            out_reg;
  logic            out_next;
  logic            oe_reg;
  logic            oe_next;
  logic [RW-1:0]   shift_reg;
  logic [RW-1:0]   shift_next;
  logic [CW-1:0]   cfg_shift_reg;
  logic [CW-1:0]   cfg_shift_next;
  logic [2:0]      cfg_cnt_reg;
  logic [2:0]      cfg_cnt_next;
  acsp_cfg_s       cfg_reg;
  acsp_cfg_s       cfg_next;
  logic            acquire_reg;
  logic            acquire_next;
  logic [RW-1:0]   result_reg;
  logic [RW-1:0]   result_next;

  // Result latch only refills outside a frame, so a frame never sees a change
  assign pop_if.ready = ~frame_reg;

  always_comb begin
    frame_next     = frame_reg;
    out_next       = out_reg;
    oe_next        = oe_reg;
    shift_next     = shift_reg;
    cfg_shift_next = cfg_shift_reg;
    cfg_cnt_next   = cfg_cnt_reg;
    cfg_next       = cfg_reg;
    acquire_next   = acquire_reg;
    result_next    = result_reg;
    if (!frame_reg && pop_if.valid) begin
      result_next = pop_if.data;
    end
    if (trig_fall && enable_reg) begin
      frame_next   = 1'b1;
      oe_next      = 1'b1;
      out_next     = result_reg[RW-1];
      shift_next   = {result_reg[RW-2:0], 1'b0};
      cfg_cnt_next = '0;
    end else if (frame_reg) begin
      if (trig_rise) begin
        frame_next   = 1'b0;
        oe_next      = 1'b0;
        acquire_next = 1'b0;
      end else begin
        // Only the first six rises count; later ones are ignored
        if (sck_rise && cfg_cnt_reg != `ACSP_CFG_CNT_DONE) begin
          cfg_shift_next = {cfg_shift_reg[CW-2:0], cfg_bit_s};
          cfg_cnt_next   = cfg_cnt_reg + 3'h1;
          if (cfg_cnt_reg == `ACSP_CFG_LAST) begin
            cfg_next     = acsp_cfg_s'({cfg_shift_reg[CW-2:0], cfg_bit_s});
            acquire_next = 1'b1;
          end
        end
        // Zeros follow once all result bits are out
        if (sck_fall) begin
          out_next   = shift_reg[RW-1];
          shift_next = {shift_reg[RW-2:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_reg     <= 1'b0;
      out_reg       <= 1'b0;
      oe_reg        <= 1'b0;
      shift_reg     <= '0;
      cfg_shift_reg <= '0;
      cfg_cnt_reg   <= '0;
      cfg_reg       <= '0;
      acquire_reg   <= 1'b0;
      result_reg    <= '0;
    end else begin
      frame_reg     <= frame_next;
      out_reg       <= out_next;
      oe_reg        <= oe_next;
      shift_reg     <= shift_next;
      cfg_shift_reg <= cfg_shift_next;
      cfg_cnt_reg   <= cfg_cnt_next;
      cfg_reg       <= cfg_next;
      acquire_reg   <= acquire_next;
      result_reg    <= result_next;
    end
  end

  // ========================================================================
  // Conversion engine group
  acsp_conv_e                      conv_state_reg;
  acsp_conv_e                      conv_state_next;
  logic [`ACSP_CONV_CNT_BITS-1:0]  conv_cnt_reg;
  logic [`ACSP_CONV_CNT_BITS-1:0]  conv_cnt_next;
  logic                            conv_pol_reg;
  logic                            conv_pol_next;
  logic                            push_valid_reg;
  logic                            push_valid_next;
  logic [RW-1:0]                   push_data_reg;
  logic [RW-1:0]                   push_data_next;

  // A pending push holds off the next start, so a full FIFO stalls conversions
  assign conv_start = trig_rise && frame_reg && enable_reg && !push_valid_reg;

  always_comb begin
    conv_state_next = conv_state_reg;
    conv_cnt_next   = conv_cnt_reg;
    conv_pol_next   = conv_pol_reg;
    push_valid_next = push_valid_reg;
    push_data_next  = push_data_reg;
    if (push_valid_reg && push_if.ready) begin
      push_valid_next = 1'b0;
    end
    unique case (conv_state_reg)
      ACSP_CONV_IDLE: begin
        if (conv_start) begin
          conv_state_next = ACSP_CONV_RUN;
          conv_cnt_next   = '0;
          conv_pol_next   = cfg_reg.polarity_select;
        end
      end
      ACSP_CONV_RUN: begin
        // Trigger edges are not looked at here
        if (conv_cnt_reg == CONV_LAST) begin
          conv_state_next = ACSP_CONV_IDLE;
          push_valid_next = 1'b1;
          if (conv_pol_reg) begin
            push_data_next = analog_code_i;
          end else begin
            push_data_next = {~analog_code_i[RW-1], analog_code_i[RW-2:0]};
          end
        end else begin
          conv_cnt_next = conv_cnt_reg + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_state_reg <= ACSP_CONV_IDLE;
      conv_cnt_reg   <= '0;
      conv_pol_reg   <= 1'b0;
      push_valid_reg <= 1'b0;
      push_data_reg  <= '0;
    end else begin
      conv_state_reg <= conv_state_next;
      conv_cnt_reg   <= conv_cnt_next;
      conv_pol_reg   <= conv_pol_next;
      push_valid_reg <= push_valid_next;
      push_data_reg  <= push_data_next;
    end
  end

  assign push_if.valid = push_valid_reg;
  assign push_if.data  = push_data_reg;

  // ========================================================================
  // Wishbone slave group: ack one cycle after the request, then drop
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic        wb_req;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;

  always_comb begin
    ack_next    = wb_req;
    dat_next    = dat_reg;
    enable_next = enable_reg;
    if (wb_req) begin
      dat_next = 32'h0000_0000;
      unique case (wb_adr_i)
        `ACSP_REG_CTRL: begin
          dat_next[`ACSP_CTRL_ENABLE] = enable_reg;
        end
        `ACSP_REG_STATUS: begin
          dat_next[`ACSP_ST_BUSY]       = (conv_state_reg == ACSP_CONV_RUN);
          dat_next[`ACSP_ST_FRAME]      = frame_reg;
          dat_next[`ACSP_ST_ACQUIRE]    = acquire_reg;
          dat_next[`ACSP_ST_SLEEP]      = cfg_reg.sleep_select;
          dat_next[`ACSP_ST_FIFO_EMPTY] = fifo_empty;
          dat_next[`ACSP_ST_FIFO_FULL]  = fifo_full;
          dat_next[`ACSP_ST_CFG_CNT +: 3] = cfg_cnt_reg;
        end
        `ACSP_REG_CONFIG: begin
          dat_next[CW-1:0] = cfg_reg;
        end
        `ACSP_REG_RESULT: begin
          dat_next[RW-1:0] = result_reg;
        end
        default: begin
          dat_next = 32'h0000_0000;                              // Unmapped reads zero
        end
      endcase
    end
    // Write lands at the edge where the master sees ack, while it still holds the request
    if (ack_reg && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == `ACSP_REG_CTRL) begin
      enable_next = wb_dat_i[`ACSP_CTRL_ENABLE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg    <= 1'b0;
      dat_reg    <= 32'h0000_0000;
      enable_reg <= `ACSP_CTRL_RESET;
    end else begin
      ack_reg    <= ack_next;
      dat_reg    <= dat_next;
      enable_reg <= enable_next;
    end
  end

  // ========================================================================
  // Outputs, all straight from flip-flops
  assign wb_ack_o               = ack_reg;
  assign wb_dat_o               = dat_reg;
  assign serial_result_out_o    = out_reg;
  assign serial_result_out_oe_o = oe_reg;
  assign sample_acquire_o       = acquire_reg;
  assign converting_o           = (conv_state_reg == ACSP_CONV_RUN) ? 1'b1 : 1'b0;
  assign mux_select_o           = {cfg_reg.single_diff, cfg_reg.odd_sign,
                                   cfg_reg.channel_addr_hi, cfg_reg.channel_addr_lo};
  assign polarity_select_o      = cfg_reg.polarity_select;
  assign sleep_select_o         = cfg_reg.sleep_select;

endmodule : acsp_top

// >>> testbench/acsp_checker.sv
// Concurrent checks on the converter serial port top-level pins
`timescale 1ns/1ps
`include "acsp_defines.svh"

module acsp_checker #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [`ACSP_ADR_BITS-1:0] wb_adr_i,
  input  wire logic [31:0]               wb_dat_o,
  input  wire logic                      wb_ack_o,
  input  wire logic                      conversion_trigger_i,
  input  wire logic                      sck_i,
  input  wire logic                      serial_result_out_o,
  input  wire logic                      serial_result_out_oe_o,
  input  wire logic                      sample_acquire_o,
  input  wire logic                      converting_o,
  input  wire logic [3:0]                mux_select_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // Conversion length; a counter, since 160 cycles is far beyond a repetition
  logic [8:0] conv_cnt_reg;
  logic [8:0] conv_cnt_next;
  always_comb conv_cnt_next = converting_o ? conv_cnt_reg + 9'h001 : 9'h000;
  always_ff @(posedge clk_i) conv_cnt_reg <= rst_i ? 9'h000 : conv_cnt_next;

  // ==========================================================================
  // Steps of a transfer
  sequence s_conv_run;
    converting_o [*8];
  endsequence
  sequence s_frame_closed;
    !serial_result_out_oe_o && !sample_acquire_o;
  endsequence

  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer held two cycles");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h0C |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_oe_after_fall: assert property ($rose(serial_result_out_oe_o) |->
    !conversion_trigger_i && ($past(conversion_trigger_i, 4) || $past(conversion_trigger_i, 5)))
    else $error("output enabled without a recent trigger fall");
  a_oe_release: assert property ($rose(conversion_trigger_i) |-> ##[1:5] s_frame_closed)
    else $error("output or acquire not released after trigger rise");
  a_out_on_fall: assert property ($changed(serial_result_out_o) && serial_result_out_oe_o &&
    $past(serial_result_out_oe_o) |-> !sck_i && ($past(sck_i, 3) || $past(sck_i, 4) || $past(sck_i, 5)))
    else $error("result bit changed without a shift clock fall");
  a_conv_start: assert property ($rose(conversion_trigger_i) && serial_result_out_oe_o &&
    !converting_o |-> ##[2:6] s_conv_run)
    else $error("trigger rise did not start a conversion");
  a_conv_length: assert property ($fell(converting_o) |-> conv_cnt_reg == 9'h0A0)
    else $error("conversion length not 160 cycles");
  a_cfg_at_sixth: assert property ($changed(mux_select_o) |-> $rose(sample_acquire_o))
    else $error("channel select changed outside the sixth config bit");
  a_acquire_frame: assert property ($rose(sample_acquire_o) |->
    serial_result_out_oe_o && !conversion_trigger_i)
    else $error("acquire started outside a frame");
endmodule : acsp_checker

// >>> testbench/acsp_host_model.sv
// Host controller model driving trigger, shift clock and config line
`timescale 1ns/1ps

module acsp_host_model (
  output logic      conversion_trigger_o,
  output logic      sck_o,
  output logic      serial_config_in_o,
  input  wire logic serial_result_out_i,
  input  wire logic serial_result_out_oe_i
);
  logic        link_ref;
  logic [11:0] rx_word;
  int          oe_hits;

  // ==========================================================================
  // Link reference at 125 ns, offset so its edges never meet the system clock
  initial begin
    link_ref = 1'b0;
    conversion_trigger_o = 1'b1;
    sck_o = 1'b0;
    serial_config_in_o = 1'b0;
    #3;
    forever #62.5 link_ref = ~link_ref;
  end

  // One transfer; the shift clock stands still outside it
  task automatic frame(input logic [5:0] cfg, input int pulses, input int gap);
    oe_hits = 0;
    @(negedge link_ref);
    conversion_trigger_o <= 1'b0;
    serial_config_in_o <= cfg[5];
    for (int i = 0; i < pulses; i++) begin
      @(posedge link_ref);
      sck_o <= 1'b1;
      rx_word[11-i] = serial_result_out_i;
      if (serial_result_out_oe_i === 1'b1) oe_hits++;
      @(negedge link_ref);
      sck_o <= 1'b0;
      // Past the sixth bit the line carries junk the device must ignore
      serial_config_in_o <= (i < 5) ? cfg[4-i] : ~serial_config_in_o;
    end
    repeat (7) @(negedge link_ref);
    conversion_trigger_o <= 1'b1;
    // Next fall after gap link periods; a gap of 16 outlasts the conversion time; no sleep wake is used
    repeat (gap) @(negedge link_ref);
  endtask : frame
endmodule : acsp_host_model

// >>> testbench/testbench.sv
// Self-checking bench for the converter serial port
`timescale 1ns/1ps
`include "acsp_defines.svh"

module testbench;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        conversion_trigger_i;
  logic        sck_i;
  logic        serial_config_in_i;
  logic        serial_result_out_o;
  logic        serial_result_out_oe_o;
  logic [11:0] analog_code_i;
  logic        sample_acquire_o;
  logic        converting_o;
  logic [3:0]  mux_select_o;
  logic        polarity_select_o;
  logic        sleep_select_o;
  int          err_total;
  int          n_compared;
  int          cycles;
  int          conv_cycles;

  acsp_top acsp_top_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .conversion_trigger_i, .sck_i, .serial_config_in_i, .serial_result_out_o,
    .serial_result_out_oe_o, .analog_code_i, .sample_acquire_o, .converting_o, .mux_select_o,
    .polarity_select_o, .sleep_select_o);

  acsp_host_model acsp_host_model_i (.conversion_trigger_o(conversion_trigger_i), .sck_o(sck_i),
    .serial_config_in_o(serial_config_in_i), .serial_result_out_i(serial_result_out_o),
    .serial_result_out_oe_i(serial_result_out_oe_o));

  // ==========================================================================
  // Clock, run limit and conversion length count
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (converting_o === 1'b1) conv_cycles++;
    if (cycles == 20000) begin
      err_total++;
      $display("BAD %0t run did not finish", $time);
      end_sim();
    end
  end

  task automatic end_sim();
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // ==========================================================================
  // Classic single bus cycle; waits for ack under a bounded count
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                          output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk({31'h0, wb_ack_o}, 32'h1, "bus answer");
  endtask : wb_cycle

  task automatic wb_rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    wb_cycle(1'b0, adr, 32'h0, rd);
    chk(rd, exp, what);
  endtask : wb_rd

  task automatic wb_wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] rd;
    wb_cycle(1'b1, adr, wd, rd);
  endtask : wb_wr

  // ==========================================================================
  // Scenarios
  task automatic t_reset_values();
    wb_rd(`ACSP_REG_CTRL, 32'h1, "ctrl reset");
    wb_rd(`ACSP_REG_STATUS, 32'h10, "status reset");
    wb_wr(`ACSP_REG_RESULT, 32'hFFF);                    // Read-only place, write must vanish
    wb_rd(`ACSP_REG_RESULT, 32'h0, "result reset");
    wb_wr(8'h10, 32'hFFFFFFFF);
    wb_rd(8'h10, 32'h0, "unmapped read");
  endtask : t_reset_values

  // All 16 channel codes, both polarities, zero-crossing boundary codes
  task automatic t_sweep();
    logic [5:0]  cfg;
    logic [11:0] code;
    logic [11:0] exp_res;
    logic [11:0] prev;
    prev = 12'h000;
    for (int k = 0; k < 17; k++) begin
      cfg = {k[3:0], k[1], k[2]};
      case (k[1:0])
        2'h0: code = 12'h7FF;
        2'h1: code = 12'h800;
        2'h2: code = 12'h000;
        default: code = 12'h001;
      endcase
      exp_res = k[1] ? code : {~code[11], code[10:0]};
      @(posedge clk_i);
      analog_code_i <= code;
      acsp_host_model_i.frame(cfg, 12, 16);
      chk({20'h0, acsp_host_model_i.rx_word}, {20'h0, prev}, "shifted result");
      chk(acsp_host_model_i.oe_hits, 32'hC, "output enable in frame");
      chk({26'h0, mux_select_o, polarity_select_o, sleep_select_o}, {26'h0, cfg}, "config pins");
      wb_rd(`ACSP_REG_CONFIG, {26'h0, cfg}, "config reg");
      wb_rd(`ACSP_REG_RESULT, {20'h0, exp_res}, "result reg");
      prev = exp_res;
    end
  endtask : t_sweep

  // With the enable cleared a frame must neither drive nor reconfigure
  task automatic t_disabled();
    wb_wr(`ACSP_REG_CTRL, 32'h0);
    acsp_host_model_i.frame(6'h3F, 12, 16);
    chk(acsp_host_model_i.oe_hits, 32'h0, "disabled frame drove");
    chk({28'h0, mux_select_o}, 32'h0, "disabled frame configured");
    wb_rd(`ACSP_REG_RESULT, 32'hFFF, "disabled result");
    wb_wr(`ACSP_REG_CTRL, 32'h1);
  endtask : t_disabled

  // A trigger pulse inside a running conversion must not restart it
  task automatic t_no_restart();
    @(posedge clk_i);
    analog_code_i <= 12'hA5C;
    acsp_host_model_i.frame(6'h02, 12, 0);
    chk({20'h0, acsp_host_model_i.rx_word}, 32'hFFF, "prior result");
    conv_cycles = 0;
    acsp_host_model_i.frame(6'h02, 0, 16);
    chk(conv_cycles, 32'hA0, "conversion length");
    acsp_host_model_i.frame(6'h02, 12, 16);
    chk({20'h0, acsp_host_model_i.rx_word}, 32'hA5C, "result after pulse");
  endtask : t_no_restart

  // ==========================================================================
  // Main sequence; trigger held high by the host through reset
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    analog_code_i = 12'h000;
    err_total = 0;
    n_compared = 0;
    cycles = 0;
    conv_cycles = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_sweep();
    t_disabled();
    t_no_restart();
    end_sim();
  end
endmodule : testbench

bind acsp_top acsp_checker #(.FIFO_DEPTH(FIFO_DEPTH)) acsp_checker_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .conversion_trigger_i, .sck_i, .serial_result_out_o,
  .serial_result_out_oe_o, .sample_acquire_o, .converting_o, .mux_select_o);
